/* File: hdl/cfts_core.sv */
// frame timing, frame number, correction stepping and acquisition engine
//
// The register offsets and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
module cfts_core #(
   parameter int FRAME_LEN = cfts_pkg::FRAME_CYC,
   parameter int SAMP_W = 18
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [cfts_pkg::AW-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [cfts_pkg::DW-1:0] wb_dat_i,
   output logic [cfts_pkg::DW-1:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic sync_pulse_i,
   input wire logic refclk_present_i,
   input wire logic freq_lock_i,
   input wire logic det_valid_i,
   input wire logic [cfts_pkg::CODE_W-1:0] det_code_i,
   input wire logic [cfts_pkg::CODE_W-1:0] det_cofs_i,
   input wire logic [cfts_pkg::SIR_W-1:0] det_sir_i,
   output logic tx_burst_o,
   output logic [cfts_pkg::CODE_W-1:0] tx_code_o,
   output logic [cfts_pkg::CODE_W-1:0] tx_cofs_o,
   output logic meas_en_o,
   output logic burst_on_pilot_o,
   output logic refclk_avail_o,
   output logic frame_strobe_o,
   output logic [cfts_pkg::SFN_W-1:0] sfn_o
);
   import cfts_pkg::*;
   localparam logic [SAMP_W-1:0] LAST_NOM = SAMP_W'(FRAME_LEN - 1);
   localparam logic [SAMP_W-1:0] ONE_S = SAMP_W'(1);
   localparam logic [SAMP_W-1:0] CHK_S = SAMP_W'(SYNC_CHK);
   localparam logic signed [ADJ_AMT_W-1:0] RES_ONE = 16'sh0001;

   ////////////////////////////////////////////////////////////////////////
   // register bus
   logic ack_q;
   logic acc;
   logic wr;
   logic [DW-1:0] bmask;
   logic [DW-1:0] ctrl_q;
   logic [DW-1:0] sched_q;
   logic [DW-1:0] code_q;
   logic [DW-1:0] refofs_q;
   logic [DW-1:0] acq_q;
   logic [DW-1:0] rdata;
   logic adj_wr;
   logic sfn_wr;
   logic sched_wr;
   logic stat_wr;
   logic acq_cmd;

   assign acc = wb_cyc_i && wb_stb_i && !ack_q;
   // writes land at the edge where the master samples ack
   assign wr = wb_cyc_i && wb_stb_i && ack_q && wb_we_i;
   assign bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   assign adj_wr = wr && (wb_adr_i == OFS_ADJ);
   assign sfn_wr = wr && (wb_adr_i == OFS_SFN);
   assign sched_wr = wr && (wb_adr_i == OFS_SCHED);
   assign stat_wr = wr && (wb_adr_i == OFS_STAT) && wb_sel_i[0];
   assign acq_cmd = wr && (wb_adr_i == OFS_CTRL) && wb_sel_i[0] && wb_dat_i[CTRL_ACQ];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= RESET_WORD;
         sched_q <= RESET_WORD;
         code_q <= RESET_WORD;
         refofs_q <= RESET_WORD;
         acq_q <= RESET_WORD;
      end else if (ce_i && wr) begin
         case (wb_adr_i)
            OFS_CTRL: ctrl_q <= (ctrl_q & ~bmask) | (wb_dat_i & bmask);
            OFS_SCHED: sched_q <= (sched_q & ~bmask) | (wb_dat_i & bmask);
            OFS_CODE: code_q <= (code_q & ~bmask) | (wb_dat_i & bmask);
            OFS_REFOFS: refofs_q <= (refofs_q & ~bmask) | (wb_dat_i & bmask);
            OFS_ACQ: acq_q <= (acq_q & ~bmask) | (wb_dat_i & bmask);
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // frame timing and frame number
   cfts_state_type state_q;
   logic [SFN_W-1:0] sfn_q;
   logic [SAMP_W-1:0] samp_q;
   logic [SAMP_W-1:0] last_q;
   logic signed [ADJ_AMT_W-1:0] resid_q;
   logic [SFN_W-1:0] start_q;
   logic armed_q;
   logic active_q;
   logic frame_end;
   logic [SFN_W-1:0] sfn_nx;
   logic start_now;
   logic stepping;
   logic best_valid_q;
   logic [2:0] best_rel_q;
   logic [SAMP_W-1:0] best_samp_q;
   logic [SFN_W-1:0] win_rel;
   logic in_win;
   logic jump;
   logic [SFN_W-1:0] jmp_sfn;
   logic [SAMP_W-1:0] jmp_samp;
   logic ref_load;
   logic coarse_q;

   assign frame_end = (samp_q == last_q);
   assign sfn_nx = sfn_q + 12'h001;
   assign ref_load = ctrl_q[CTRL_REF] && sync_pulse_i;
   // initial phase starts at the next frame boundary, steady state waits for the named frame
   assign start_now = armed_q && frame_end && (ctrl_q[CTRL_INIT] || (sfn_nx == start_q));
   assign stepping = frame_end && (active_q || start_now) && (resid_q != '0);
   assign win_rel = sfn_q - (acq_q[SFN_W-1:0] - ACQ_HALF);
   assign in_win = (win_rel <= ACQ_SPAN);
   assign jump = (state_q == ST_ACQ) && frame_end && (win_rel == ACQ_SPAN) && best_valid_q;
   // earliest burst marks system frame at window centre, sample zero
   assign jmp_sfn = sfn_nx + ACQ_HALF - {9'h000, best_rel_q} - {11'h000, (best_samp_q != '0)};
   assign jmp_samp = (best_samp_q == '0) ? '0 : (LAST_NOM + ONE_S - best_samp_q);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         samp_q <= '0;
         last_q <= LAST_NOM;
         sfn_q <= '0;
      end else if (ce_i) begin
         if (ref_load) begin
            // reference marker is frame zero of the epoch plus offset
            samp_q <= '0;
            last_q <= LAST_NOM;
            sfn_q <= refofs_q[SFN_W-1:0];
         end else if (sfn_wr) begin
            sfn_q <= wb_dat_i[SFN_W-1:0];
         end else if (jump) begin
            samp_q <= jmp_samp;
            last_q <= LAST_NOM;
            sfn_q <= jmp_sfn;
         end else if (frame_end) begin
            samp_q <= '0;
            sfn_q <= sfn_nx;
            if (stepping && resid_q > 0) begin
               last_q <= LAST_NOM + ONE_S;
            end else if (stepping) begin
               last_q <= LAST_NOM - ONE_S;
            end else begin
               last_q <= LAST_NOM;
            end
         end else begin
            samp_q <= samp_q + ONE_S;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // commanded correction
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         resid_q <= '0;
         start_q <= '0;
         armed_q <= 1'b0;
         active_q <= 1'b0;
      end else if (ce_i) begin
         if (adj_wr) begin
            resid_q <= wb_dat_i[ADJ_AMT_LSB +: ADJ_AMT_W];
            start_q <= wb_dat_i[ADJ_SFN_LSB +: SFN_W];
            armed_q <= 1'b1;
            active_q <= 1'b0;
         end else begin
            if (start_now) begin
               armed_q <= 1'b0;
               active_q <= 1'b1;
            end else if (active_q && resid_q == '0) begin
               active_q <= 1'b0;
            end
            if (stepping && resid_q > 0) begin
               resid_q <= resid_q - RES_ONE;
            end else if (stepping) begin
               resid_q <= resid_q + RES_ONE;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // schedule, acquisition and measurement
   cfts_sched_if sif ();
   logic det_match;
   logic slot_hit;
   logic slot_chk;

   assign sif.sfn = sfn_q;
   assign sif.cyc_log2 = sched_q[SCH_CYC_LSB +: SCH_CYC_W];
   assign sif.reps = sched_q[SCH_REP_LSB +: SFN_W];
   assign sif.offset = sched_q[SCH_OFS_LSB +: SFN_W];

   cfts_sched u_sched (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .ce_i (ce_i),
      .sif (sif.sched)
   );

   assign det_match = det_valid_i && (det_code_i == code_q[CODE_MC_LSB +: CODE_W])
                      && (det_cofs_i == code_q[CODE_MO_LSB +: CODE_W]);
   assign slot_chk = ctrl_q[CTRL_EN] && (samp_q == CHK_S);
   assign slot_hit = slot_chk && (state_q == ST_STEADY) && sif.is_sync;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= ST_IDLE;
         best_valid_q <= 1'b0;
         best_rel_q <= '0;
         best_samp_q <= '0;
      end else if (ce_i) begin
         case (state_q)
            ST_IDLE, ST_STEADY: begin
               if (acq_cmd && coarse_q) begin
                  state_q <= ST_ACQ;
                  best_valid_q <= 1'b0;
               end else if (sched_wr) begin
                  state_q <= ST_STEADY;
               end
            end
            ST_ACQ: begin
               if (det_match && meas_en_o && in_win && (!best_valid_q
                   || {win_rel[2:0], samp_q} < {best_rel_q, best_samp_q})) begin
                  best_valid_q <= 1'b1;
                  best_rel_q <= win_rel[2:0];
                  best_samp_q <= samp_q;
               end
               if (frame_end && (win_rel == ACQ_SPAN)) begin
                  state_q <= best_valid_q ? ST_WAIT_RECONF : ST_IDLE;
               end
            end
            ST_WAIT_RECONF: begin
               if (sched_wr) begin
                  state_q <= ST_STEADY;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // status flags, set wins over clear
   logic done_q;
   logic late_q;
   logic rpt_q;
   logic acqfail_q;
   logic lock_q;
   logic [SFN_W-1:0] rpt_sfn_q;
   logic [SAMP_W-1:0] rpt_samp_q;
   logic [SIR_W-1:0] rpt_sir_q;
   logic rpt_set;

   assign rpt_set = det_match && meas_en_o && ctrl_q[CTRL_EN];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         done_q <= 1'b0;
         late_q <= 1'b0;
         rpt_q <= 1'b0;
         acqfail_q <= 1'b0;
         coarse_q <= 1'b0;
         lock_q <= 1'b0;
      end else if (ce_i) begin
         done_q <= (active_q && resid_q == '0) || (done_q && !(stat_wr && wb_dat_i[STAT_DONE]));
         late_q <= (slot_hit && active_q) || (late_q && !(stat_wr && wb_dat_i[STAT_LATE]));
         rpt_q <= rpt_set || (rpt_q && !(stat_wr && wb_dat_i[STAT_RPT]));
         acqfail_q <= ((state_q == ST_ACQ) && frame_end && (win_rel == ACQ_SPAN) && !best_valid_q)
                      || (acqfail_q && !(stat_wr && wb_dat_i[STAT_ACQFAIL]));
         coarse_q <= coarse_q || sfn_wr || ref_load;
         lock_q <= freq_lock_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rpt_sfn_q <= '0;
         rpt_samp_q <= '0;
         rpt_sir_q <= '0;
      end else if (ce_i && rpt_set) begin
         rpt_sfn_q <= sfn_q;
         rpt_samp_q <= samp_q;
         rpt_sir_q <= det_sir_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // radio side outputs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_burst_o <= 1'b0;
         meas_en_o <= 1'b0;
         tx_code_o <= '0;
         tx_cofs_o <= '0;
         burst_on_pilot_o <= 1'b0;
         refclk_avail_o <= 1'b0;
         frame_strobe_o <= 1'b0;
      end else if (ce_i) begin
         // initial phase bursts every frame, steady state on sync frames only
         tx_burst_o <= slot_chk && ctrl_q[CTRL_TX]
                       && (ctrl_q[CTRL_INIT] || (state_q == ST_STEADY && sif.is_sync));
         if (slot_chk) begin
            meas_en_o <= ((state_q == ST_ACQ) && in_win) || (!ctrl_q[CTRL_TX]
                         && (ctrl_q[CTRL_INIT] || (state_q == ST_STEADY && sif.is_sync)));
         end
         tx_code_o <= code_q[CODE_TXC_LSB +: CODE_W];
         tx_cofs_o <= code_q[CODE_TXO_LSB +: CODE_W];
         burst_on_pilot_o <= ctrl_q[CTRL_NARROW];
         refclk_avail_o <= refclk_present_i;
         frame_strobe_o <= frame_end;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read mux and acknowledge
   always_comb begin
      rdata = '0;
      case (wb_adr_i)
         OFS_CTRL: rdata = ctrl_q;
         OFS_STAT: rdata = {22'h000000, 2'(state_q), active_q, refclk_avail_o, lock_q, coarse_q,
                            acqfail_q, rpt_q, late_q, done_q};
         OFS_SFN: rdata = {20'h00000, sfn_q};
         OFS_ADJ: rdata = {4'h0, start_q, 16'(resid_q)};
         OFS_SCHED: rdata = sched_q;
         OFS_CODE: rdata = code_q;
         OFS_REFOFS: rdata = refofs_q;
         OFS_RPT_TIME: rdata = {(DW-SAMP_W)'(0), rpt_samp_q};
         OFS_RPT_INFO: rdata = {8'h00, rpt_sir_q, 4'h0, rpt_sfn_q};
         OFS_ACQ: rdata = acq_q;
         default: rdata = '0;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         wb_dat_o <= '0;
      end else if (ce_i) begin
         ack_q <= acc;
         wb_dat_o <= acc ? rdata : '0;
      end
   end
   assign wb_ack_o = ack_q;
   assign sfn_o = sfn_q;

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   step_size_a: assert property (ce_i && !adj_wr |=> (resid_q == $past(resid_q))
      || (resid_q == $past(resid_q) + RES_ONE) || (resid_q == $past(resid_q) - RES_ONE))
      else $error("residual moved by more than one sample");
   step_edge_a: assert property (ce_i && !adj_wr && !frame_end |=> $stable(resid_q))
      else $error("residual changed inside a frame");
   adj_start_a: assert property (ce_i && !adj_wr && armed_q && frame_end && sfn_nx == start_q
      |=> active_q && !armed_q) else $error("correction did not start at its frame");
   no_early_a: assert property (ce_i && armed_q && !active_q && !start_now |=> !active_q)
      else $error("correction started early");
   late_flag_a: assert property (ce_i && slot_hit && active_q |=> late_q)
      else $error("unfinished correction at slot not flagged");
   win_only_a: assert property ($rose(best_valid_q) |-> $past(in_win) && $past(det_match))
      else $error("burst accepted outside search window");
   coarse_gate_a: assert property ((state_q == ST_ACQ) |-> coarse_q)
      else $error("acquisition without coarse number");
   jump_time_a: assert property (ce_i && jump |=> state_q == ST_WAIT_RECONF
      && sfn_q == $past(jmp_sfn) && samp_q == $past(jmp_samp)) else $error("acquisition jump wrong");
   ref_load_a: assert property (ce_i && ref_load && !wr |=> sfn_q == refofs_q[SFN_W-1:0]
      && samp_q == '0) else $error("reference frame number not loaded");
   done_flag_a: assert property (ce_i && active_q && resid_q == '0 && !adj_wr
      |=> done_q && !active_q) else $error("completion not flagged");
   init_tx_a: assert property (ce_i && slot_chk && ctrl_q[CTRL_TX] && ctrl_q[CTRL_INIT]
      |=> tx_burst_o ##1 !tx_burst_o) else $error("initial phase burst missing");
   reconf_a: assert property (ce_i && state_q == ST_WAIT_RECONF && sched_wr |=> state_q == ST_STEADY)
      else $error("reconfiguration did not enter steady state");
endmodule : cfts_core

/* File: hdl/cfts_pkg.sv */
// constants, field layouts and types of the cell frame timing sync block
// Summary of operation
// - correction starts at frame of commanded number, or at next frame in initial phase
// - correction done before next sync burst slot; core only sets late flag if still active at a steady-state sync slot
// - correction steps only at frame boundaries
// - at most one sample step per frame
// - sync frames from cycles, repetitions and offset
// - bursts told apart by code and offset
// - send, measure and report per schedule
// - acquisition search window three frames each side
// - adopt earliest burst, jump timing and number
// - acquisition only after coarse number update
// - late entrant reports frequency lock status
// - reference cell frame zero on reference epoch
// - reference number is port value plus offset
// - initial phase: finish correction before acknowledge
// - initial phase: burst every frame, report quality
// - reconfiguration after acquisition enters steady state
// - report reference clock availability to controller
// - narrowband variant uses downlink pilot channel
// - frame number wraps every 4096 frames
package cfts_pkg;
   localparam int DW = 32;
   localparam int AW = 8;
   localparam logic [AW-1:0] OFS_CTRL = 8'h00;
   localparam logic [AW-1:0] OFS_STAT = 8'h04;
   localparam logic [AW-1:0] OFS_SFN = 8'h08;
   localparam logic [AW-1:0] OFS_ADJ = 8'h0C;
   localparam logic [AW-1:0] OFS_SCHED = 8'h10;
   localparam logic [AW-1:0] OFS_CODE = 8'h14;
   localparam logic [AW-1:0] OFS_REFOFS = 8'h18;
   localparam logic [AW-1:0] OFS_RPT_TIME = 8'h1C;
   localparam logic [AW-1:0] OFS_RPT_INFO = 8'h20;
   localparam logic [AW-1:0] OFS_ACQ = 8'h24;
   // control bits
   localparam int CTRL_EN = 0;
   localparam int CTRL_REF = 1;
   localparam int CTRL_ACQ = 2;
   localparam int CTRL_INIT = 3;
   localparam int CTRL_NARROW = 4;
   localparam int CTRL_TX = 5;
   // status bits, low four are sticky, write one to clear
   localparam int STAT_DONE = 0;
   localparam int STAT_LATE = 1;
   localparam int STAT_RPT = 2;
   localparam int STAT_ACQFAIL = 3;
   localparam int STAT_COARSE = 4;
   localparam int STAT_LOCK = 5;
   localparam int STAT_REFCLK = 6;
   localparam int STAT_ACTIVE = 7;
   localparam int STAT_STATE = 8;
   // frame numbering
   localparam int SFN_W = 12;
   localparam logic [SFN_W-1:0] SFN_ALL = 12'hFFF;
   localparam logic [SFN_W-1:0] ACQ_HALF = 12'h003;
   localparam logic [SFN_W-1:0] ACQ_SPAN = 12'h006;
   // field layouts
   localparam int ADJ_AMT_LSB = 0;
   localparam int ADJ_AMT_W = 16;
   localparam int ADJ_SFN_LSB = 16;
   localparam int SCH_CYC_LSB = 0;
   localparam int SCH_CYC_W = 4;
   localparam int SCH_REP_LSB = 4;
   localparam int SCH_OFS_LSB = 16;
   localparam int CODE_W = 8;
   localparam int CODE_TXC_LSB = 0;
   localparam int CODE_TXO_LSB = 8;
   localparam int CODE_MC_LSB = 16;
   localparam int CODE_MO_LSB = 24;
   localparam int RPT_SIR_LSB = 16;
   localparam int SIR_W = 8;
   // timing
   localparam int FRAME_NS = 10000000;
   localparam int CLK_NS = 50;
   localparam int FRAME_CYC = FRAME_NS / CLK_NS;
   localparam int SYNC_CHK = 1;
   localparam logic [DW-1:0] RESET_WORD = 32'h0000_0000;
   typedef enum logic [1:0] {ST_IDLE, ST_ACQ, ST_WAIT_RECONF, ST_STEADY} cfts_state_type;
endpackage : cfts_pkg

/* File: hdl/cfts_sched_if.sv */
// carrier between timing core and sync frame scheduler
`timescale 1ns/1ps
interface cfts_sched_if;
   import cfts_pkg::*;
   logic [SFN_W-1:0] sfn;
   logic [SCH_CYC_W-1:0] cyc_log2;
   logic [SFN_W-1:0] reps;
   logic [SFN_W-1:0] offset;
   logic is_sync;
   modport core (output sfn, output cyc_log2, output reps, output offset, input is_sync);
   modport sched (input sfn, input cyc_log2, input reps, input offset, output is_sync);
endinterface : cfts_sched_if

/* File: hdl/cfts_sched.sv */
// sync frame decision: frame is a burst frame of the cycle schedule
`timescale 1ns/1ps
module cfts_sched (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   cfts_sched_if.sched sif
);
   import cfts_pkg::*;
   logic [SFN_W-1:0] mask;
   logic [SFN_W:0] cyc_len;
   logic [SFN_W-1:0] pos;
   logic [2*SFN_W-1:0] prod;
   logic [SFN_W:0] rem;
   logic hit;
   // cycle length is the period shifted down, so mod is a mask
   assign mask = SFN_ALL >> sif.cyc_log2;
   assign cyc_len = {1'b0, mask} + 13'h0001;
   assign pos = (sif.sfn - sif.offset) & mask;
   assign prod = pos * sif.reps;
   assign rem = {1'b0, prod[SFN_W-1:0] & mask};
   // floor(i*L/R) == pos  <=>  pos*R mod L is 0 or above L-R
   assign hit = (sif.reps != '0) && ({1'b0, sif.reps} <= cyc_len)
                && ((rem == '0) || (rem > (cyc_len - {1'b0, sif.reps})));
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sif.is_sync <= 1'b0;
      end else if (ce_i) begin
         sif.is_sync <= hit;
      end
   end
endmodule : cfts_sched

/* File: test/cfts_rnc.sv */
// controller model: classic wishbone master issuing commands and collecting reports
`timescale 1ns/1ps
module cfts_rnc (
   input wire logic clk_i,
   input wire logic ack_i,
   input wire logic [cfts_pkg::DW-1:0] dat_i,
   output logic cyc_o,
   output logic stb_o,
   output logic we_o,
   output logic [3:0] sel_o,
   output logic [cfts_pkg::AW-1:0] adr_o,
   output logic [cfts_pkg::DW-1:0] dat_o
);
   import cfts_pkg::*;
   initial begin
      {cyc_o, stb_o, we_o, sel_o, adr_o, dat_o} = '0;
   end
   // one word per access, held until ack; sends no alert-gated correction, no slot enable
   task automatic xfer(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d, output logic [DW-1:0] q);
      @(posedge clk_i);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o <= w;
      sel_o <= 4'hF;
      adr_o <= a;
      dat_o <= d;
      // only the bench timeout ends a wait for ack
      do begin
         @(posedge clk_i);
      end while (ack_i !== 1'b1);
      q = dat_i;
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
   endtask : xfer
endmodule : cfts_rnc

/* File: test/cell_frame_timing_sync_bench.sv */
// bench: acquisition, schedule, wrap, correction and reference load against a model
`timescale 1ns/1ps
module cell_frame_timing_sync_bench;
   import cfts_pkg::*;
   localparam int FL = 40;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc, stb, we, ack, tx, meas, pil, rav, fs, fl = 1'b0, ini = 1'b0;
   logic [3:0] sel;
   logic sp = 1'b0, rp = 1'b0, rp1 = 1'b0, dv = 1'b0, seen = 1'b0, son = 1'b0;
   logic [AW-1:0] adr;
   logic [DW-1:0] wd, rd, v, cw;
   logic [7:0] dc = 8'h00, dof = 8'h00, dsir = 8'h00, txc, txo;
   logic [SFN_W-1:0] sfn, pf = 12'h000, c, s;
   int failures = 0, tests_run = 0, cycles = 0, flen = 0, t0, lg, reps, ofs, amt, mag;
   int len_of [int];
   int offs [4] = '{-4, -2, -1, 1};
   always #25 clk_i = ~clk_i;
   cfts_rnc u_cfts_rnc (.clk_i(clk_i), .ack_i(ack), .dat_i(rd), .cyc_o(cyc), .stb_o(stb), .we_o(we),
      .sel_o(sel), .adr_o(adr), .dat_o(wd));
   cfts_core #(.FRAME_LEN(FL)) u_cfts_core (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rd),
      .wb_ack_o(ack), .sync_pulse_i(sp), .refclk_present_i(rp), .freq_lock_i(fl), .det_valid_i(dv),
      .det_code_i(dc), .det_cofs_i(dof), .det_sir_i(dsir), .tx_burst_o(tx), .tx_code_o(txc),
      .tx_cofs_o(txo), .meas_en_o(meas), .burst_on_pilot_o(pil), .refclk_avail_o(rav),
      .frame_strobe_o(fs), .sfn_o(sfn));
   ////////////////////////////////////////
   task automatic conclude();
      if (failures == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : conclude
   task automatic chk(input logic [DW-1:0] g, input logic [DW-1:0] e);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %0t got %0h exp %0h", $time, g, e);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
      u_cfts_rnc.xfer(w, a, d, v);
   endtask : bus
   task automatic frames(input int n);
      repeat (n) do @(posedge clk_i); while (fs !== 1'b1);
   endtask : frames
   task automatic to_frame(input logic [SFN_W-1:0] f);
      do @(posedge clk_i); while (fs !== 1'b1 || sfn !== f);
   endtask : to_frame
   function automatic logic is_sync(input int f);
      int l;
      l = 4096 >> lg;
      for (int i = 0; i < reps; i++)
         if (i * l / reps == ((f - ofs) % l + l) % l)
            return 1'b1;
      return 1'b0;
   endfunction : is_sync
   ////////////////////////////////////////
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      flen <= flen + 1;
      rp1 <= rp;
      if (cycles > 1)
         chk(rav, rp1);
      if (tx === 1'b1) begin
         seen <= 1'b1;
         chk({txo, txc}, cw[15:0]);
      end
      if (fs === 1'b1) begin
         if (son)
            chk(seen, ini | is_sync(pf));
         len_of[pf] = flen;
         pf <= sfn;
         seen <= 1'b0;
         flen <= 1;
         rp <= 1'($urandom_range(0, 1));
      end
      if (cycles == 20000) begin
         failures++;
         conclude();
      end
   end
   initial begin
      void'($urandom(32'hAF139FCA));
      cw = $urandom();
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      bus(0, OFS_STAT, 0);
      chk(v, 0);
      bus(0, 8'hFC, 0);
      chk(v, 0);
      fl <= 1'($urandom_range(0, 1));
      bus(1, OFS_CTRL, 32'h5);
      bus(0, OFS_STAT, 0);
      chk(v[9:8], 0);
      c = 12'(100 + $urandom_range(0, 50));
      bus(1, OFS_CODE, cw);
      bus(1, OFS_SFN, 32'(c - 12'd6));
      bus(1, OFS_ACQ, 32'(c));
      bus(1, OFS_CTRL, 32'h5);
      bus(0, OFS_STAT, 0);
      chk(v[9:8], 1);
      // outside window, wrong code, earliest, later
      for (int i = 0; i < 4; i++) begin
         to_frame(c + 12'(offs[i]));
         repeat (4) @(posedge clk_i);
         chk(meas, i > 0);
         dv <= 1'b1;
         dc <= (i == 1) ? ~cw[23:16] : cw[23:16];
         dof <= cw[31:24];
         dsir <= 8'($urandom());
         @(posedge clk_i);
         dv <= 1'b0;
         if (i == 2)
            t0 = cycles;
      end
      to_frame(c + 12'd5);
      bus(0, OFS_STAT, 0);
      chk(v[9:8], 2);
      chk(v[3], 0);
      // last accepted report: frame c+1, fifth sample after its start
      bus(0, OFS_RPT_TIME, 0);
      chk(v, 5);
      bus(0, OFS_RPT_INFO, 0);
      chk(v, {8'h00, dsir, 4'h0, c + 12'd1});
      while ((cycles - t0) % FL != 20)
         @(posedge clk_i);
      chk(sfn, (c + (cycles - t0) / FL) & 12'hFFF);
      lg = 10;
      reps = $urandom_range(1, 3);
      ofs = $urandom_range(0, 3);
      bus(1, OFS_SCHED, (ofs << 16) | (reps << 4) | lg);
      bus(0, OFS_STAT, 0);
      chk(v[9:8], 3);
      bus(1, OFS_CTRL, 32'h31);
      frames(2);
      chk(pil, 1);
      son <= 1'b1;
      frames(12);
      son <= 1'b0;
      bus(1, OFS_SFN, 32'hFFE);
      frames(3);
      chk(sfn, 1);
      son <= 1'b1;
      amt = $urandom_range(1, 3);
      if ($urandom_range(0, 1))
         amt = -amt;
      mag = amt < 0 ? -amt : amt;
      s = sfn + 12'd3;
      bus(1, OFS_ADJ, {4'h0, s, 16'(amt)});
      to_frame(s + 12'd4);
      @(posedge clk_i);
      for (int k = -1; k < 4; k++)
         chk(len_of[s + k], (k >= 0 && k < mag) ? FL + amt / mag : FL);
      bus(0, OFS_STAT, 0);
      chk(v[0], 1);
      chk(v[5], fl);
      son <= 1'b0;
      bus(1, OFS_REFOFS, 32'(c));
      bus(1, OFS_CTRL, 32'h3);
      sp <= 1'b1;
      @(posedge clk_i);
      sp <= 1'b0;
      repeat (FL + 20) @(posedge clk_i);
      chk(sfn, c + 12'd1);
      // initial phase: a burst in every frame
      bus(1, OFS_CTRL, 32'h29);
      ini <= 1'b1;
      frames(1);
      son <= 1'b1;
      frames(3);
      conclude();
   end
endmodule : cell_frame_timing_sync_bench
